// *** inc/ccfh_pkg.sv ***
`default_nettype none
package ccfh_pkg;
  // Byte addresses of the register words
  localparam logic [7:0] ADDR_CTRL_VALUE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_BITS = 8'h04;
  localparam logic [7:0] ADDR_FB_COUNT = 8'h08;
  localparam logic [7:0] ADDR_FB_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_LOAD_VALUE = 8'h10;
  localparam logic [7:0] ADDR_CONFIG = 8'h14;
  localparam logic [7:0] ADDR_LIMIT_HI = 8'h18;
  localparam logic [7:0] ADDR_LIMIT_LO = 8'h1C;
  // Control word bits
  localparam int CB_SOFTWARE_GATE_CONTROL = 0;
  localparam int CB_SYNC_EN = 1;
  localparam int CB_CLR_REQ = 2;
  localparam int CB_ERR_ACK = 7;
  localparam int CB_LOAD_DIRECT = 8;
  localparam int CB_LOAD_PREP = 9;
  localparam int CB_CMP1 = 10;
  localparam int CB_CMP2 = 11;
  localparam int CB_OUT_PARAM = 12;
  localparam logic [31:0] CTRL_BITS_MASK = 32'h00001F87;
  // Feedback status word bits
  localparam int FB_LOAD_BUSY = 0;
  localparam int FB_LOAD_ERR = 1;
  localparam int FB_CLR_ACT = 2;
  localparam int FB_PARAM_ERR = 5;
  localparam int FB_SUPPLY_ERR = 7;
  localparam int FB_GATE = 8;
  localparam int FB_DI = 9;
  localparam int FB_UP = 14;
  localparam int FB_DOWN = 15;
  localparam int FB_SYNC = 16;
  localparam int FB_UPPER = 21;
  localparam int FB_LOWER = 22;
  localparam int FB_ZERO = 23;
  // Configuration word bits
  localparam int CF_GROUP_DIAG = 0;
  localparam int CF_ISOCHRONE = 1;
  localparam int CF_ISO_SIX = 2;
  localparam int CF_STOP = 3;
  localparam int CF_NO_MAIN_DIR = 4;
  localparam int CF_DI_FUNC = 5;
  localparam int CF_HWGATE_INV = 7;
  localparam logic [31:0] CONFIG_MASK = 32'h000000FF;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [31:0] RST_LIMIT_HI = 32'h7FFFFFFF;
  localparam logic [31:0] RST_LIMIT_LO = 32'h80000000;
  // Bus cycles per acknowledgement in isochrone mode
  localparam logic [2:0] ISO_CYCLES_FOUR = 3'h4;
  localparam logic [2:0] ISO_CYCLES_SIX = 3'h6;
  localparam logic [2:0] ISO_CYCLES_NONE = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    DI_INPUT = 2'b00, DI_HW_GATE = 2'b01, DI_LATCH = 2'b10, DI_SYNC = 2'b11
  } ccfh_di_func_t;
  typedef enum logic [1:0] {
    CLR_IDLE = 2'b00, CLR_WAIT = 2'b01, CLR_ACTIVE = 2'b10
  } ccfh_clr_state_t;
  typedef enum logic {
    LD_IDLE = 1'b0, LD_WAIT = 1'b1
  } ccfh_ld_state_t;
endpackage : ccfh_pkg
`default_nettype wire

// *** logic/ccfh_pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccfh_pin_sync #(
  parameter int W = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] s1_r, s2_r, s3_r, level_r, level_nxt;
  // Level only moves once two late stages agree, filtering one-cycle glitches
  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      always_comb begin
        level_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : level_r[i];
      end
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
          level_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= pin_i[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          level_r[i] <= level_nxt[i];
        end
      end
    end
  endgenerate
  assign level_o = level_r;
endmodule : ccfh_pin_sync
`default_nettype wire

// *** logic/ccfh_top.sv ***
`timescale 1ns/100ps
`default_nettype none
// How it works
// - synchronization only while sync enable set
// - supply error held until acknowledged after cause gone
// - preparatory load stores value, count untouched
// - direct load replaces count with value
// - request, clear plus active, drop, active drops
// - software gate follows its control bit
// - supply short sets sticky error, diagnostic
// - several load requests together flag error
// - invalid load value rejected, error flagged
// - load error held until later correct load
// - digital input level mirrored in every mode
// - internal gate state reported while counting
// - busy flag while load is carried out
// - sticky zero crossing without main direction
// - sticky upper and lower limit flags
// - sync done sticky until status clear
// - isochrone handshakes take 4 or 6 cycles
// - diagnostic only with group diagnostics enabled
// - parameter error cleared by correct parameters
// - acknowledge held or stop: errors follow cause
// - feedback count is live or latched value
module ccfh_top
  import ccfh_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic count_up_i,
  input wire logic count_down_i,
  input wire logic digital_input_i,
  input wire logic supply_short_i,
  output logic diag_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  logic [3:0] pin_level;
  logic up_filt, dn_filt, di_filt, short_filt;
  ccfh_pin_sync #(.W(4)) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i({supply_short_i, digital_input_i, count_down_i, count_up_i}),
    .level_o(pin_level)
  );
  assign {short_filt, di_filt, dn_filt, up_filt} = pin_level;

  // Bus slave state
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic do_write, bus_tick;
  // Software registers
  logic [31:0] ctrl_value_r, ctrl_value_nxt, ctrl_bits_r, ctrl_bits_nxt;
  logic [31:0] config_r, config_nxt, limit_hi_r, limit_hi_nxt, limit_lo_r, limit_lo_nxt;
  logic param_err_r, param_err_nxt;
  // Counter core state
  logic [31:0] count_r, count_nxt, load_value_r, load_value_nxt, latch_r, latch_nxt;
  logic [31:0] pend_value_r, pend_value_nxt;
  logic pend_prep_r, pend_prep_nxt;
  logic [15:0] req_prev_r, req_prev_nxt;
  logic up_prev_r, up_prev_nxt, dn_prev_r, dn_prev_nxt, di_prev_r, di_prev_nxt;
  logic gate_r, gate_nxt, di_level_r, di_level_nxt, diag_r, diag_nxt;
  logic dir_up_r, dir_up_nxt, dir_dn_r, dir_dn_nxt;
  logic sync_done_r, sync_done_nxt, zero_r, zero_nxt;
  logic upper_r, upper_nxt, lower_r, lower_nxt;
  logic supply_err_r, supply_err_nxt, load_err_r, load_err_nxt;
  ccfh_clr_state_t clr_state_r, clr_state_nxt;
  ccfh_ld_state_t ld_state_r, ld_state_nxt;
  logic [2:0] clr_cnt_r, clr_cnt_nxt, ld_cnt_r, ld_cnt_nxt;
  // Decoded events
  logic [15:0] req_rise;
  logic [4:0] load_reqs;
  logic conflict, ld_start, ld_fire, ld_valid, clr_fire, live, up_ev, dn_ev, di_rise;
  logic [2:0] iso_target;
  ccfh_di_func_t di_func;
  logic [31:0] status_word;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res & mask;
  endfunction : merge

  // Write channel: address and data taken in either order, answered once both held
  always_comb begin
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    do_write = aw_full_r & w_full_r & ~bvalid_r;
    if (s_axi_awvalid_i & awready_r) begin
      awaddr_nxt = s_axi_awaddr_i;
      aw_full_nxt = 1'b1;
    end
    if (s_axi_wvalid_i & wready_r) begin
      wdata_nxt = s_axi_wdata_i;
      wstrb_nxt = s_axi_wstrb_i;
      w_full_nxt = 1'b1;
    end
    if (do_write) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
    end
    awready_nxt = ~aw_full_nxt;
    wready_nxt = ~w_full_nxt;
    bvalid_nxt = do_write | (bvalid_r & ~s_axi_bready_i);
    bresp_nxt = bresp_r;
    if (do_write) begin
      bresp_nxt = (awaddr_r[7:5] == 3'h0 && awaddr_r[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end
    bus_tick = do_write & (awaddr_r == ADDR_CTRL_BITS);
  end

  // Read channel: one outstanding read, data latched when address taken
  always_comb begin
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid_i & arready_r) begin
      rresp_nxt = RESP_OKAY;
      unique case (s_axi_araddr_i)
        ADDR_CTRL_VALUE: rdata_nxt = ctrl_value_r;
        ADDR_CTRL_BITS: rdata_nxt = ctrl_bits_r;
        ADDR_FB_COUNT: rdata_nxt = (di_func == DI_LATCH) ? latch_r : count_r;
        ADDR_FB_STATUS: rdata_nxt = status_word;
        ADDR_LOAD_VALUE: rdata_nxt = load_value_r;
        ADDR_CONFIG: rdata_nxt = config_r;
        ADDR_LIMIT_HI: rdata_nxt = limit_hi_r;
        ADDR_LIMIT_LO: rdata_nxt = limit_lo_r;
        default: begin
          rdata_nxt = RST_WORD;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    rvalid_nxt = (s_axi_arvalid_i & arready_r) | (rvalid_r & ~s_axi_rready_i);
    arready_nxt = ~rvalid_nxt;
  end

  // Software writable registers; parameter error judged on each config write
  always_comb begin
    ctrl_value_nxt = ctrl_value_r;
    ctrl_bits_nxt = ctrl_bits_r;
    config_nxt = config_r;
    limit_hi_nxt = limit_hi_r;
    limit_lo_nxt = limit_lo_r;
    param_err_nxt = param_err_r;
    if (do_write) begin
      unique case (awaddr_r)
        ADDR_CTRL_VALUE: ctrl_value_nxt = merge(ctrl_value_r, wdata_r, wstrb_r, '1);
        ADDR_CTRL_BITS: ctrl_bits_nxt = merge(ctrl_bits_r, wdata_r, wstrb_r, CTRL_BITS_MASK);
        ADDR_CONFIG: begin
          config_nxt = merge(config_r, wdata_r, wstrb_r, CONFIG_MASK);
          // Ack bit has no say here; only a sound parameter set clears it
          param_err_nxt = config_nxt[CF_HWGATE_INV] &
                          (config_nxt[CF_DI_FUNC +: 2] != DI_HW_GATE);
        end
        ADDR_LIMIT_HI: limit_hi_nxt = merge(limit_hi_r, wdata_r, wstrb_r, '1);
        ADDR_LIMIT_LO: limit_lo_nxt = merge(limit_lo_r, wdata_r, wstrb_r, '1);
        default: ;
      endcase
    end
  end

  // Event decode shared by the core
  always_comb begin
    di_func = ccfh_di_func_t'(config_r[CF_DI_FUNC +: 2]);
    req_rise = ctrl_bits_r[15:0] & ~req_prev_r;
    load_reqs = ctrl_bits_r[CB_OUT_PARAM:CB_LOAD_DIRECT];
    conflict = ($countones(load_reqs) > 1);
    ld_start = (ld_state_r == LD_IDLE) & ~conflict &
               (req_rise[CB_LOAD_DIRECT] | req_rise[CB_LOAD_PREP]);
    iso_target = ~config_r[CF_ISOCHRONE] ? ISO_CYCLES_NONE :
                 (config_r[CF_ISO_SIX] ? ISO_CYCLES_SIX : ISO_CYCLES_FOUR);
    ld_fire = (ld_state_r == LD_WAIT) & (ld_cnt_r >= iso_target);
    clr_fire = (clr_state_r == CLR_WAIT) & (clr_cnt_r >= iso_target);
    ld_valid = ($signed(pend_value_r) <= $signed(limit_hi_r)) &
               ($signed(pend_value_r) >= $signed(limit_lo_r));
    live = ctrl_bits_r[CB_ERR_ACK] | config_r[CF_STOP];
    up_ev = up_filt & ~up_prev_r & gate_r & ~dn_filt;
    dn_ev = dn_filt & ~dn_prev_r & gate_r & ~up_filt;
    di_rise = di_filt & ~di_prev_r;
    status_word = RST_WORD;
    status_word[FB_LOAD_BUSY] = (ld_state_r == LD_WAIT);
    status_word[FB_LOAD_ERR] = load_err_r;
    status_word[FB_CLR_ACT] = (clr_state_r == CLR_ACTIVE);
    status_word[FB_PARAM_ERR] = param_err_r;
    status_word[FB_SUPPLY_ERR] = supply_err_r;
    status_word[FB_GATE] = gate_r;
    status_word[FB_DI] = di_level_r;
    status_word[FB_UP] = dir_up_r;
    status_word[FB_DOWN] = dir_dn_r;
    status_word[FB_SYNC] = sync_done_r;
    status_word[FB_UPPER] = upper_r;
    status_word[FB_LOWER] = lower_r;
    status_word[FB_ZERO] = zero_r;
  end

  // Handshake sequencers; isochrone counts bus cycles as control word writes
  always_comb begin
    clr_state_nxt = clr_state_r;
    clr_cnt_nxt = clr_cnt_r + {2'h0, bus_tick};
    ld_state_nxt = ld_state_r;
    ld_cnt_nxt = ld_cnt_r + {2'h0, bus_tick};
    pend_value_nxt = pend_value_r;
    pend_prep_nxt = pend_prep_r;
    unique case (clr_state_r)
      CLR_IDLE: begin
        clr_cnt_nxt = 3'h0;
        if (req_rise[CB_CLR_REQ]) begin
          clr_state_nxt = CLR_WAIT;
        end
      end
      CLR_WAIT: begin
        if (clr_fire) begin
          clr_state_nxt = CLR_ACTIVE;
        end
      end
      CLR_ACTIVE: begin
        if (!ctrl_bits_r[CB_CLR_REQ]) begin
          clr_state_nxt = CLR_IDLE;
        end
      end
      default: clr_state_nxt = CLR_IDLE;
    endcase
    unique case (ld_state_r)
      LD_IDLE: begin
        ld_cnt_nxt = 3'h0;
        if (ld_start) begin
          ld_state_nxt = LD_WAIT;
          pend_value_nxt = ctrl_value_r;
          pend_prep_nxt = req_rise[CB_LOAD_PREP];
        end
      end
      LD_WAIT: begin
        if (ld_fire) begin
          ld_state_nxt = LD_IDLE;
        end
      end
    endcase
  end

  // Counter, flags and errors; in every flag a fresh set beats the clear
  always_comb begin
    count_nxt = count_r;
    load_value_nxt = load_value_r;
    latch_nxt = latch_r;
    req_prev_nxt = ctrl_bits_r[15:0];
    up_prev_nxt = up_filt;
    dn_prev_nxt = dn_filt;
    di_prev_nxt = di_filt;
    di_level_nxt = di_filt;
    gate_nxt = ctrl_bits_r[CB_SOFTWARE_GATE_CONTROL] &
               ((di_func != DI_HW_GATE) | (di_filt ^ config_r[CF_HWGATE_INV]));
    dir_up_nxt = dir_up_r | up_ev;
    dir_dn_nxt = dir_dn_r | dn_ev;
    if (up_ev) begin
      dir_dn_nxt = 1'b0;
    end
    if (dn_ev) begin
      dir_up_nxt = 1'b0;
    end
    sync_done_nxt = sync_done_r & ~clr_fire;
    zero_nxt = zero_r & ~clr_fire;
    upper_nxt = upper_r & ~clr_fire;
    lower_nxt = lower_r & ~clr_fire;
    if (up_ev) begin
      if (count_r == limit_hi_r) begin
        count_nxt = limit_lo_r;
        upper_nxt = 1'b1;
      end else begin
        count_nxt = count_r + 32'h00000001;
      end
      if (config_r[CF_NO_MAIN_DIR] && count_r == 32'hFFFFFFFF) begin
        zero_nxt = 1'b1;
      end
    end else if (dn_ev) begin
      if (count_r == limit_lo_r) begin
        count_nxt = limit_hi_r;
        lower_nxt = 1'b1;
      end else begin
        count_nxt = count_r - 32'h00000001;
      end
      if (config_r[CF_NO_MAIN_DIR] && count_r == 32'h00000000) begin
        zero_nxt = 1'b1;
      end
    end
    if (di_rise && di_func == DI_LATCH) begin
      latch_nxt = count_r;
    end
    if (di_rise && di_func == DI_SYNC && ctrl_bits_r[CB_SYNC_EN]) begin
      count_nxt = load_value_r;
      sync_done_nxt = 1'b1;
    end
    load_err_nxt = load_err_r;
    if (ld_fire) begin
      if (!ld_valid) begin
        load_err_nxt = 1'b1;
      end else if (pend_prep_r) begin
        load_value_nxt = pend_value_r;
        load_err_nxt = 1'b0;
      end else begin
        count_nxt = pend_value_r;
        load_err_nxt = 1'b0;
      end
    end
    if (live && !ld_fire) begin
      load_err_nxt = 1'b0;
    end
    if (conflict) begin
      load_err_nxt = 1'b1;
    end
    // Live mode mirrors the cause; otherwise the flag waits for acknowledge
    supply_err_nxt = live ? short_filt : (supply_err_r | short_filt);
    diag_nxt = config_r[CF_GROUP_DIAG] &
               (supply_err_r | param_err_r | load_err_r);
  end

  // All state registered in one place
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      awaddr_r <= 8'h00;
      wdata_r <= RST_WORD;
      wstrb_r <= 4'h0;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= RST_WORD;
      ctrl_value_r <= RST_WORD;
      ctrl_bits_r <= RST_WORD;
      config_r <= RST_WORD;
      limit_hi_r <= RST_LIMIT_HI;
      limit_lo_r <= RST_LIMIT_LO;
      param_err_r <= 1'b0;
      count_r <= RST_WORD;
      load_value_r <= RST_WORD;
      latch_r <= RST_WORD;
      pend_value_r <= RST_WORD;
      pend_prep_r <= 1'b0;
      req_prev_r <= 16'h0000;
      up_prev_r <= 1'b0;
      dn_prev_r <= 1'b0;
      di_prev_r <= 1'b0;
      gate_r <= 1'b0;
      di_level_r <= 1'b0;
      diag_r <= 1'b0;
      dir_up_r <= 1'b0;
      dir_dn_r <= 1'b0;
      sync_done_r <= 1'b0;
      zero_r <= 1'b0;
      upper_r <= 1'b0;
      lower_r <= 1'b0;
      supply_err_r <= 1'b0;
      load_err_r <= 1'b0;
      clr_state_r <= CLR_IDLE;
      ld_state_r <= LD_IDLE;
      clr_cnt_r <= 3'h0;
      ld_cnt_r <= 3'h0;
    end else begin
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ctrl_value_r <= ctrl_value_nxt;
      ctrl_bits_r <= ctrl_bits_nxt;
      config_r <= config_nxt;
      limit_hi_r <= limit_hi_nxt;
      limit_lo_r <= limit_lo_nxt;
      param_err_r <= param_err_nxt;
      count_r <= count_nxt;
      load_value_r <= load_value_nxt;
      latch_r <= latch_nxt;
      pend_value_r <= pend_value_nxt;
      pend_prep_r <= pend_prep_nxt;
      req_prev_r <= req_prev_nxt;
      up_prev_r <= up_prev_nxt;
      dn_prev_r <= dn_prev_nxt;
      di_prev_r <= di_prev_nxt;
      gate_r <= gate_nxt;
      di_level_r <= di_level_nxt;
      diag_r <= diag_nxt;
      dir_up_r <= dir_up_nxt;
      dir_dn_r <= dir_dn_nxt;
      sync_done_r <= sync_done_nxt;
      zero_r <= zero_nxt;
      upper_r <= upper_nxt;
      lower_r <= lower_nxt;
      supply_err_r <= supply_err_nxt;
      load_err_r <= load_err_nxt;
      clr_state_r <= clr_state_nxt;
      ld_state_r <= ld_state_nxt;
      clr_cnt_r <= clr_cnt_nxt;
      ld_cnt_r <= ld_cnt_nxt;
    end
  end

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rresp_o = rresp_r;
  assign s_axi_rdata_o = rdata_r;
  assign diag_o = diag_r;

  // Checks of the documented behaviour
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_clr_done;
    clr_fire ##1 (clr_state_r == CLR_ACTIVE);
  endsequence
  sequence s_req_dropped;
    (clr_state_r == CLR_ACTIVE) && !ctrl_bits_r[CB_CLR_REQ];
  endsequence
  AST_SYNC_ENABLE: assert property ($rose(sync_done_r) |-> $past(ctrl_bits_r[CB_SYNC_EN]))
    else $error("sync done without sync enable");
  AST_ERR_HOLD: assert property (supply_err_r && !live && !short_filt |=> supply_err_r)
    else $error("supply error lost before acknowledge");
  AST_PREP_LOAD: assert property (ld_fire && ld_valid && pend_prep_r |=>
    load_value_r == $past(pend_value_r)) else $error("preparatory value not stored");
  AST_DIRECT_LOAD: assert property (ld_fire && ld_valid && !pend_prep_r |=>
    count_r == $past(pend_value_r)) else $error("direct load not applied");
  AST_CLR_HANDSHAKE: assert property (clr_fire |-> s_clr_done)
    else $error("clear active not raised");
  AST_CLR_RELEASE: assert property (s_req_dropped |=> clr_state_r == CLR_IDLE)
    else $error("clear active not dropped");
  AST_GATE_CLOSE: assert property (!ctrl_bits_r[CB_SOFTWARE_GATE_CONTROL] |=> !gate_r)
    else $error("gate open with control bit clear");
  AST_SHORT_SET: assert property (short_filt |=> supply_err_r)
    else $error("supply short not flagged");
  AST_CONFLICT: assert property (conflict |=> load_err_r)
    else $error("conflicting requests not flagged");
  AST_INVALID: assert property (ld_fire && !ld_valid |=>
    load_err_r && load_value_r == $past(load_value_r)) else $error("invalid load accepted");
  AST_DI_MIRROR: assert property (di_level_r == $past(di_filt))
    else $error("input level not mirrored");
  AST_LOAD_BUSY: assert property (ld_start |=> status_word[FB_LOAD_BUSY])
    else $error("busy flag missing during load");
  AST_LIVE_CLEAR: assert property (live && !short_filt |=> !supply_err_r)
    else $error("live error not cleared");
endmodule : ccfh_top
`default_nettype wire

// *** test/ccfh_enc_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccfh_enc_model (
  input wire logic sys_clk_i,
  input wire logic go_i,
  output logic up_o
);
  // Three slow pulses per request, well clear of the pin filter delay
  initial up_o = 1'b0;
  always @(posedge go_i) begin
    repeat (3) begin
      repeat (8) @(posedge sys_clk_i);
      up_o <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      up_o <= 1'b0;
    end
  end
endmodule : ccfh_enc_model
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ccfh_pkg::*;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, count_up_i, count_down_i = 1'b0;
  logic digital_input_i = 1'b0, supply_short_i = 1'b0, diag_o, enc_go = 1'b0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h00000000, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  int err_total = 0, n_checks = 0, cyc = 0;
  localparam logic [7:0] C = ADDR_CTRL_BITS;
  localparam logic [7:0] S = ADDR_FB_STATUS;
  localparam logic [7:0] N = ADDR_FB_COUNT;
  localparam logic [7:0] V = ADDR_CTRL_VALUE;
  ccfh_top dut_u (.*);
  ccfh_enc_model enc_u (.sys_clk_i(sys_clk_i), .go_i(enc_go), .up_o(count_up_i));
  // Free-running system clock
  always #50 sys_clk_i = ~sys_clk_i;
  task automatic end_of_test();
    $display("Checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : idle
  // Leading edge keeps two tasks from driving one signal in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while ((s_axi_awvalid_i && !s_axi_awready_o) || (s_axi_wvalid_i && !s_axi_wready_o));
    while (!s_axi_bvalid_o) @(posedge sys_clk_i);
    s_axi_bready_i <= 1'b0;
    chk({30'h00000000, s_axi_bresp_o}, {30'h00000000, r});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] r = RESP_OKAY);
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(posedge sys_clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge sys_clk_i); while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
    chk(s_axi_rdata_o & m, e);
    chk({30'h00000000, s_axi_rresp_o}, {30'h00000000, r});
  endtask : rd
  // Main sequence; each load request but the last is dropped again so edges stay clean
  initial begin
    idle(10);
    rst_i <= 1'b0;
    rd(ADDR_LIMIT_HI, RST_LIMIT_HI);
    rd(8'h40, 32'h00000000, 32'hFFFFFFFF, RESP_SLVERR);
    wr(8'h40, 32'h00000001, RESP_SLVERR);
    wr(V, 32'h00000005);
    wr(C, 32'h00000100);
    idle(10);
    rd(N, 32'h00000005);
    wr(C, 32'h00000000);
    wr(V, 32'h00000007);
    wr(C, 32'h00000200);
    idle(10);
    rd(N, 32'h00000005);
    rd(ADDR_LOAD_VALUE, 32'h00000007);
    digital_input_i <= 1'b1;
    wr(C, 32'h00000001);
    enc_go <= 1'b1;
    idle(60);
    enc_go <= 1'b0;
    rd(N, 32'h00000008);
    rd(S, 32'h00000300, 32'h00000300);
    wr(C, 32'h00000000);
    enc_go <= 1'b1;
    idle(60);
    enc_go <= 1'b0;
    rd(N, 32'h00000008);
    wr(V, 32'h00000003);
    wr(C, 32'h00000300);
    rd(S, 32'h00000002, 32'h00000002);
    wr(C, 32'h00000000);
    rd(S, 32'h00000002, 32'h00000002);
    wr(C, 32'h00000100);
    idle(10);
    rd(N, 32'h00000003);
    rd(S, 32'h00000000, 32'h00000002);
    wr(C, 32'h00000000);
    wr(ADDR_LIMIT_HI, 32'h00000064);
    wr(V, 32'h000000C8);
    wr(C, 32'h00000100);
    idle(10);
    rd(N, 32'h00000003);
    rd(S, 32'h00000002, 32'h00000002);
    wr(C, 32'h00000000);
    wr(ADDR_CONFIG, 32'h00000080);
    rd(S, 32'h00000020, 32'h00000020);
    wr(ADDR_CONFIG, 32'h00000001);
    rd(S, 32'h00000000, 32'h00000020);
    supply_short_i <= 1'b1;
    idle(10);
    rd(S, 32'h00000080, 32'h00000080);
    chk({31'h00000000, diag_o}, 32'h00000001);
    supply_short_i <= 1'b0;
    idle(10);
    rd(S, 32'h00000080, 32'h00000080);
    wr(C, 32'h00000080);
    idle(5);
    wr(C, 32'h00000000);
    rd(S, 32'h00000000, 32'h00000082);
    chk({31'h00000000, diag_o}, 32'h00000000);
    digital_input_i <= 1'b0;
    wr(ADDR_CONFIG, 32'h00000060);
    digital_input_i <= 1'b1;
    idle(10);
    rd(N, 32'h00000003);
    digital_input_i <= 1'b0;
    wr(C, 32'h00000002);
    digital_input_i <= 1'b1;
    idle(10);
    rd(N, 32'h00000007);
    rd(S, 32'h00010000, 32'h00010000);
    wr(C, 32'h00000004);
    idle(5);
    rd(S, 32'h00000004, 32'h00010004);
    wr(C, 32'h00000000);
    idle(5);
    rd(S, 32'h00000000, 32'h00000004);
    // Count from minus one through zero up to a low ceiling so it wraps
    wr(ADDR_CONFIG, 32'h00000010);
    wr(ADDR_LIMIT_HI, 32'h00000001);
    wr(V, 32'hFFFFFFFF);
    wr(C, 32'h00000101);
    enc_go <= 1'b1;
    idle(60);
    enc_go <= 1'b0;
    rd(N, 32'h80000000);
    rd(S, 32'h00A04000, 32'h00E0C000);
    // Latch mode shows the held value, zero until the first input rise
    wr(ADDR_CONFIG, 32'h00000040);
    rd(N, 32'h00000000);
    digital_input_i <= 1'b0;
    idle(5);
    digital_input_i <= 1'b1;
    idle(8);
    rd(N, 32'h80000000);
    // Isochrone: the raising write plus four more control writes
    wr(ADDR_CONFIG, 32'h00000002);
    repeat (4) wr(C, 32'h00000004);
    rd(S, 32'h00000000, 32'h00000004);
    wr(C, 32'h00000004);
    rd(S, 32'h00000004, 32'h00A00004);
    wr(C, 32'h00000100);
    rd(S, 32'h00000001, 32'h00000005);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
